// file: include/video_rate_remapper_pkg.sv
// Overview of operation
// - convert among 1, 2, 4 pixels per beat
// - rates come from registers, low eight bits
// - earliest pixel sits in lowest slot
// - component order inside a pixel untouched
// - pixels moved as opaque bit groups
// - height and width, low sixteen bits each
// - colour format code, reset value one
// - drop and repeat enables in bit zero
// - one clock for bus and streams
// - reset restores all register defaults
// - unpack input beats by input rate
// - widen then narrow to output rate
// - repack words onto output stream
// - conversion only with build option set
//
// constants, field layouts and carrier types for the pixel rate remapper
// assumes one 50 MHz clock and a 32-bit register slave in front of it

package video_rate_remapper_pkg;

	// ************************************************************
	// geometry of the pixel data
	// ************************************************************
	localparam int PIXEL_BITS = 48; // widest pixel: three 16-bit components
	localparam int MAX_PPB = 4; // widest beat in pixels
	localparam int ACC_SLOTS = 8; // gather buffer, holds n_out plus n_in, four each at most
	localparam int FIFO_DEPTH = 16; // beats buffered between stages

	// ************************************************************
	// register map, byte addresses
	// ************************************************************
	localparam logic [7:0] OFS_STATUS = 8'h00; // read-only block state
	localparam logic [7:0] OFS_FRAME_HEIGHT = 8'h10;
	localparam logic [7:0] OFS_FRAME_WIDTH = 8'h18;
	localparam logic [7:0] OFS_COLOUR_FORMAT = 8'h20;
	localparam logic [7:0] OFS_IN_PPB = 8'h28;
	localparam logic [7:0] OFS_OUT_PPB = 8'h30;
	localparam logic [7:0] OFS_RSVD_A = 8'h38;
	localparam logic [7:0] OFS_RSVD_B = 8'h40;
	localparam logic [7:0] OFS_DROP_EN = 8'h48;
	localparam logic [7:0] OFS_REPEAT_EN = 8'h50;

	// field widths of each register
	localparam int GEOM_BITS = 16;
	localparam int FMT_BITS = 8;
	localparam int PPB_BITS = 8;

	// reset values
	localparam logic [15:0] RST_GEOM = 16'h0000;
	localparam logic [7:0] RST_FORMAT = 8'h01;
	localparam logic [7:0] RST_PPB = 8'h00;
	localparam logic RST_ENABLE = 1'b0;

	// colour format codes
	localparam logic [7:0] FMT_444 = 8'h01;
	localparam logic [7:0] FMT_422_420 = 8'h03;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one stream beat as carried through the buffer
	typedef struct packed {
		logic sof; // start of frame
		logic eol; // end of line
		logic [MAX_PPB-1:0][PIXEL_BITS-1:0] pix; // slot 0 is earliest pixel
	} beat_t;

endpackage : video_rate_remapper_pkg

// file: hw/video_rate_remapper.sv
// beat buffer and the pixel rate remapper top level
// assumes a synchronous upstream source, a downstream sink and a
// 32-bit register master, all on clk

`timescale 1ns/10ps

// ************************************************************
// beat buffer
// ************************************************************
module beat_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr; // next write slot
	logic [AW-1:0] rd_ptr; // oldest word
	logic [AW:0] fill; // words held
	logic push;
	logic pop;

	// full and empty come straight from the fill count
	assign in_ready = (fill != (AW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	// storage array, no reset needed on data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// fill level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fill <= '0;
		end else if (push && !pop) begin
			fill <= fill + 1'b1;
		end else if (pop && !push) begin
			fill <= fill - 1'b1;
		end
	end
endmodule : beat_fifo

// ************************************************************
// pixel rate remapper
// ************************************************************
module video_rate_remapper #(
	parameter bit CONVERT_EN = 1'b1, // build option for rate conversion
	parameter int DEPTH = video_rate_remapper_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	// register slave, write side
	input wire logic [7:0] s_axi_ctrl_awaddr,
	input wire logic s_axi_ctrl_awvalid,
	output logic s_axi_ctrl_awready,
	input wire logic [31:0] s_axi_ctrl_wdata,
	input wire logic [3:0] s_axi_ctrl_wstrb,
	input wire logic s_axi_ctrl_wvalid,
	output logic s_axi_ctrl_wready,
	output logic [1:0] s_axi_ctrl_bresp,
	output logic s_axi_ctrl_bvalid,
	input wire logic s_axi_ctrl_bready,
	// register slave, read side
	input wire logic [7:0] s_axi_ctrl_araddr,
	input wire logic s_axi_ctrl_arvalid,
	output logic s_axi_ctrl_arready,
	output logic [31:0] s_axi_ctrl_rdata,
	output logic [1:0] s_axi_ctrl_rresp,
	output logic s_axi_ctrl_rvalid,
	input wire logic s_axi_ctrl_rready,
	// input video stream
	input wire logic [video_rate_remapper_pkg::MAX_PPB*video_rate_remapper_pkg::PIXEL_BITS-1:0]
		s_axis_video_tdata,
	input wire logic s_axis_video_tvalid,
	output logic s_axis_video_tready,
	input wire logic s_axis_video_tuser,
	input wire logic s_axis_video_tlast,
	// output video stream
	output logic [video_rate_remapper_pkg::MAX_PPB*video_rate_remapper_pkg::PIXEL_BITS-1:0]
		m_axis_video_tdata,
	output logic m_axis_video_tvalid,
	input wire logic m_axis_video_tready,
	output logic m_axis_video_tuser,
	output logic m_axis_video_tlast
);
	import video_rate_remapper_pkg::*;

	// unsupported codes fall back to one pixel, so a zero rate still moves video
	function automatic logic [3:0] decode_ppb(input logic [7:0] code);
		if (code == 8'h02) begin
			decode_ppb = 4'h2;
		end else if (code == 8'h04) begin
			decode_ppb = 4'h4;
		end else begin
			decode_ppb = 4'h1;
		end
	endfunction : decode_ppb

	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
		end
	endfunction : merge

	// ************************************************************
	// registers
	// ************************************************************
	logic [GEOM_BITS-1:0] frame_height; // lines per frame
	logic [GEOM_BITS-1:0] frame_width; // pixels per line
	logic [FMT_BITS-1:0] colour_format_code; // sampling code
	logic [PPB_BITS-1:0] input_pixels_per_beat; // input rate
	logic [PPB_BITS-1:0] output_pixels_per_beat; // output rate
	logic input_drop_enable; // held only, feature not active
	logic output_repeat_enable; // held only, feature not active
	logic [15:0] line_count; // output lines seen this frame
	logic busy; // pixels still inside the block

	logic wr_go; // address and data both present
	logic [31:0] wr_old; // current value of addressed register
	logic [31:0] wr_val; // merged write value
	logic wr_hit; // address is mapped
	logic [31:0] rd_val; // read mux
	logic rd_hit;

	// write takes address and data together, one at a time
	assign wr_go = s_axi_ctrl_awvalid & s_axi_ctrl_wvalid & ~s_axi_ctrl_bvalid;
	assign s_axi_ctrl_awready = wr_go;
	assign s_axi_ctrl_wready = wr_go;
	assign s_axi_ctrl_arready = ~s_axi_ctrl_rvalid;
	assign wr_val = merge(wr_old, s_axi_ctrl_wdata, s_axi_ctrl_wstrb);

	// old value for byte merge and mapped-address check on writes
	always_comb begin
		wr_old = '0;
		wr_hit = 1'b1;
		if (s_axi_ctrl_awaddr == OFS_FRAME_HEIGHT) begin
			wr_old = {16'h0000, frame_height};
		end else if (s_axi_ctrl_awaddr == OFS_FRAME_WIDTH) begin
			wr_old = {16'h0000, frame_width};
		end else if (s_axi_ctrl_awaddr == OFS_COLOUR_FORMAT) begin
			wr_old = {24'h000000, colour_format_code};
		end else if (s_axi_ctrl_awaddr == OFS_IN_PPB) begin
			wr_old = {24'h000000, input_pixels_per_beat};
		end else if (s_axi_ctrl_awaddr == OFS_OUT_PPB) begin
			wr_old = {24'h000000, output_pixels_per_beat};
		end else if (s_axi_ctrl_awaddr == OFS_DROP_EN) begin
			wr_old = {31'h00000000, input_drop_enable};
		end else if (s_axi_ctrl_awaddr == OFS_REPEAT_EN) begin
			wr_old = {31'h00000000, output_repeat_enable};
		end else if (s_axi_ctrl_awaddr == OFS_RSVD_A || s_axi_ctrl_awaddr == OFS_RSVD_B) begin
			wr_old = '0; // accepted, ignored
		end else begin
			wr_hit = 1'b0; // unmapped, status is read-only too
		end
	end

	// register storage; all on the one clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_height <= RST_GEOM;
			frame_width <= RST_GEOM;
			colour_format_code <= RST_FORMAT;
			input_pixels_per_beat <= RST_PPB;
			output_pixels_per_beat <= RST_PPB;
			input_drop_enable <= RST_ENABLE;
			output_repeat_enable <= RST_ENABLE;
		end else if (wr_go) begin
			if (s_axi_ctrl_awaddr == OFS_FRAME_HEIGHT) begin
				frame_height <= wr_val[GEOM_BITS-1:0];
			end else if (s_axi_ctrl_awaddr == OFS_FRAME_WIDTH) begin
				frame_width <= wr_val[GEOM_BITS-1:0];
			end else if (s_axi_ctrl_awaddr == OFS_COLOUR_FORMAT) begin
				colour_format_code <= wr_val[FMT_BITS-1:0];
			end else if (s_axi_ctrl_awaddr == OFS_IN_PPB) begin
				input_pixels_per_beat <= wr_val[PPB_BITS-1:0];
			end else if (s_axi_ctrl_awaddr == OFS_OUT_PPB) begin
				output_pixels_per_beat <= wr_val[PPB_BITS-1:0];
			end else if (s_axi_ctrl_awaddr == OFS_DROP_EN) begin
				input_drop_enable <= wr_val[0];
			end else if (s_axi_ctrl_awaddr == OFS_REPEAT_EN) begin
				output_repeat_enable <= wr_val[0];
			end
		end
	end

	// write answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_ctrl_bvalid <= 1'b0;
			s_axi_ctrl_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_ctrl_bvalid <= 1'b1;
			s_axi_ctrl_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_ctrl_bready) begin
			s_axi_ctrl_bvalid <= 1'b0;
		end
	end

	// read mux; reserved words read zero
	always_comb begin
		rd_val = '0;
		rd_hit = 1'b1;
		if (s_axi_ctrl_araddr == OFS_STATUS) begin
			rd_val = {line_count, 15'h0000, busy};
		end else if (s_axi_ctrl_araddr == OFS_FRAME_HEIGHT) begin
			rd_val = {16'h0000, frame_height};
		end else if (s_axi_ctrl_araddr == OFS_FRAME_WIDTH) begin
			rd_val = {16'h0000, frame_width};
		end else if (s_axi_ctrl_araddr == OFS_COLOUR_FORMAT) begin
			rd_val = {24'h000000, colour_format_code};
		end else if (s_axi_ctrl_araddr == OFS_IN_PPB) begin
			rd_val = {24'h000000, input_pixels_per_beat};
		end else if (s_axi_ctrl_araddr == OFS_OUT_PPB) begin
			rd_val = {24'h000000, output_pixels_per_beat};
		end else if (s_axi_ctrl_araddr == OFS_DROP_EN) begin
			rd_val = {31'h00000000, input_drop_enable};
		end else if (s_axi_ctrl_araddr == OFS_REPEAT_EN) begin
			rd_val = {31'h00000000, output_repeat_enable};
		end else if (s_axi_ctrl_araddr == OFS_RSVD_A || s_axi_ctrl_araddr == OFS_RSVD_B) begin
			rd_val = '0;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read answer, registered
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_ctrl_rvalid <= 1'b0;
			s_axi_ctrl_rdata <= '0;
			s_axi_ctrl_rresp <= RESP_OKAY;
		end else if (s_axi_ctrl_arvalid && !s_axi_ctrl_rvalid) begin
			s_axi_ctrl_rvalid <= 1'b1;
			s_axi_ctrl_rdata <= rd_val;
			s_axi_ctrl_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_ctrl_rready) begin
			s_axi_ctrl_rvalid <= 1'b0;
		end
	end

	// ************************************************************
	// unpack stage: input beats into the buffer
	// ************************************************************
	beat_t in_beat; // incoming beat as carried
	beat_t f_beat; // oldest buffered beat
	logic f_valid;
	logic accept; // gather stage takes the buffered beat
	logic [3:0] n_in; // pixels per input beat
	logic [3:0] n_out; // pixels per output beat

	// slot order is kept as is: slot 0 is the earliest pixel
	assign in_beat = '{sof: s_axis_video_tuser, eol: s_axis_video_tlast,
		pix: s_axis_video_tdata};
	assign n_in = decode_ppb(input_pixels_per_beat);
	// without the build option the output rate simply follows the input
	assign n_out = CONVERT_EN ? decode_ppb(output_pixels_per_beat) : n_in;

	beat_fifo #(
		.WIDTH($bits(beat_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_data(in_beat),
		.in_valid(s_axis_video_tvalid),
		.in_ready(s_axis_video_tready),
		.out_data(f_beat),
		.out_valid(f_valid),
		.out_ready(accept)
	);

	// ************************************************************
	// widen and narrow: gather pixels, cut output beats
	// ************************************************************
	logic [ACC_SLOTS-1:0][PIXEL_BITS-1:0] acc; // pixels waiting, slot 0 oldest
	logic [3:0] acc_cnt; // pixels waiting
	logic eol_pend; // last pixel of a line is in acc
	logic sof_pend; // first pixel of a frame is in acc
	logic load; // output register takes a beat
	logic [3:0] emit_n; // pixels in that beat
	logic [3:0] remain; // pixels left after the cut
	logic line_done; // the cut takes the line's last pixel
	logic [ACC_SLOTS-1:0][PIXEL_BITS-1:0] next_acc;
	logic take; // downstream takes a beat

	assign take = m_axis_video_tvalid & m_axis_video_tready;
	assign emit_n = (acc_cnt >= n_out) ? n_out : acc_cnt;
	// a short beat is cut only at a line end, so no pixel is held back
	assign load = (!m_axis_video_tvalid || m_axis_video_tready)
		&& (acc_cnt >= n_out || (eol_pend && acc_cnt != 4'h0));
	assign remain = load ? acc_cnt - emit_n : acc_cnt;
	assign line_done = load && eol_pend && (emit_n == acc_cnt);
	// lines never mix in acc, and acc never overflows its eight slots
	assign accept = f_valid && (!eol_pend || line_done)
		&& (5'(remain) + 5'(n_in) <= 5'(ACC_SLOTS));
	assign busy = f_valid || (acc_cnt != 4'h0) || m_axis_video_tvalid;

	// shift out the cut pixels, append the new beat after the rest
	always_comb begin
		next_acc = '0;
		for (int i = 0; i < ACC_SLOTS; i++) begin
			if (i + int'(load ? emit_n : 4'h0) < ACC_SLOTS) begin
				next_acc[i] = acc[i + int'(load ? emit_n : 4'h0)];
			end
		end
		for (int j = 0; j < MAX_PPB; j++) begin
			if (accept && j < int'(n_in)) begin
				next_acc[int'(remain) + j] = f_beat.pix[j];
			end
		end
	end

	// gather buffer state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc <= '0;
			acc_cnt <= 4'h0;
		end else begin
			acc <= next_acc;
			acc_cnt <= remain + (accept ? n_in : 4'h0);
		end
	end

	// line and frame markers follow the pixels through acc
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			eol_pend <= 1'b0;
			sof_pend <= 1'b0;
		end else begin
			if (accept) begin
				eol_pend <= f_beat.eol;
			end else if (line_done) begin
				eol_pend <= 1'b0;
			end
			// a new frame marker wins over the clear by the cut
			if (accept && f_beat.sof) begin
				sof_pend <= 1'b1;
			end else if (load) begin
				sof_pend <= 1'b0;
			end
		end
	end

	// ************************************************************
	// repack stage: output beat register
	// ************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			m_axis_video_tvalid <= 1'b0;
			m_axis_video_tdata <= '0;
			m_axis_video_tuser <= 1'b0;
			m_axis_video_tlast <= 1'b0;
		end else if (load) begin
			m_axis_video_tvalid <= 1'b1;
			for (int j = 0; j < MAX_PPB; j++) begin
				m_axis_video_tdata[j*PIXEL_BITS +: PIXEL_BITS] <=
					(j < int'(emit_n)) ? acc[j] : '0;
			end
			m_axis_video_tuser <= sof_pend;
			m_axis_video_tlast <= line_done;
		end else if (m_axis_video_tready) begin
			m_axis_video_tvalid <= 1'b0;
		end
	end

	// output lines since the last start of frame, for software
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			line_count <= 16'h0000;
		end else if (take && m_axis_video_tuser) begin
			line_count <= m_axis_video_tlast ? 16'h0001 : 16'h0000;
		end else if (take && m_axis_video_tlast) begin
			line_count <= line_count + 16'h0001;
		end
	end
endmodule : video_rate_remapper

// file: tb/video_rate_remapper_asserts.sv
// port checker for the pixel rate remapper
// assumes one clock and the active low reset nrst
`timescale 1ns/10ps
module video_rate_remapper_asserts import video_rate_remapper_pkg::*; (
	input logic clk,
	input logic nrst,
	input logic s_axi_ctrl_awvalid,
	input logic s_axi_ctrl_wvalid,
	input logic s_axi_ctrl_awready,
	input logic [1:0] s_axi_ctrl_bresp,
	input logic s_axi_ctrl_bvalid,
	input logic s_axi_ctrl_bready,
	input logic [7:0] s_axi_ctrl_araddr,
	input logic s_axi_ctrl_arvalid,
	input logic s_axi_ctrl_arready,
	input logic [31:0] s_axi_ctrl_rdata,
	input logic [1:0] s_axi_ctrl_rresp,
	input logic s_axi_ctrl_rvalid,
	input logic s_axi_ctrl_rready,
	input logic [MAX_PPB*PIXEL_BITS-1:0] m_axis_video_tdata,
	input logic m_axis_video_tvalid,
	input logic m_axis_video_tready,
	input logic m_axis_video_tuser,
	input logic m_axis_video_tlast
);
	// ************************************************************
	// bus and stream handshakes
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// requests accepted at this edge
	sequence wr_taken;
		s_axi_ctrl_awvalid && s_axi_ctrl_wvalid && s_axi_ctrl_awready;
	endsequence
	sequence rd_taken;
		s_axi_ctrl_arvalid && s_axi_ctrl_arready;
	endsequence
	chk_write_answer: assert property (wr_taken |=> s_axi_ctrl_bvalid)
		else $error("write answer missing");
	chk_read_answer: assert property (rd_taken |=> s_axi_ctrl_rvalid)
		else $error("read answer missing");
	chk_bresp_hold: assert property (s_axi_ctrl_bvalid && !s_axi_ctrl_bready
		|=> s_axi_ctrl_bvalid && $stable(s_axi_ctrl_bresp)) else $error("bresp dropped");
	chk_rdata_hold: assert property (s_axi_ctrl_rvalid && !s_axi_ctrl_rready
		|=> s_axi_ctrl_rvalid && $stable(s_axi_ctrl_rdata) && $stable(s_axi_ctrl_rresp))
		else $error("read data dropped");
	chk_write_block: assert property (s_axi_ctrl_bvalid |-> !s_axi_ctrl_awready)
		else $error("write taken with answer pending");
	chk_read_block: assert property (s_axi_ctrl_rvalid |-> !s_axi_ctrl_arready)
		else $error("read taken with answer pending");
	// addresses past the last register are errors reading zero
	chk_unmapped_err: assert property (rd_taken ##0 s_axi_ctrl_araddr > OFS_REPEAT_EN
		|=> s_axi_ctrl_rresp == RESP_SLVERR && s_axi_ctrl_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_out_hold: assert property (m_axis_video_tvalid && !m_axis_video_tready
		|=> m_axis_video_tvalid && $stable(m_axis_video_tdata) && $stable(m_axis_video_tuser)
		&& $stable(m_axis_video_tlast)) else $error("output beat changed while stalled");
	chk_reset_quiet: assert property ($rose(nrst) |-> !m_axis_video_tvalid
		&& !s_axi_ctrl_bvalid && !s_axi_ctrl_rvalid) else $error("outputs busy after reset");
endmodule : video_rate_remapper_asserts

bind video_rate_remapper video_rate_remapper_asserts chk_u (.clk, .nrst,
	.s_axi_ctrl_awvalid, .s_axi_ctrl_wvalid, .s_axi_ctrl_awready, .s_axi_ctrl_bresp,
	.s_axi_ctrl_bvalid, .s_axi_ctrl_bready, .s_axi_ctrl_araddr, .s_axi_ctrl_arvalid,
	.s_axi_ctrl_arready, .s_axi_ctrl_rdata, .s_axi_ctrl_rresp, .s_axi_ctrl_rvalid,
	.s_axi_ctrl_rready, .m_axis_video_tdata, .m_axis_video_tvalid, .m_axis_video_tready,
	.m_axis_video_tuser, .m_axis_video_tlast);

// file: tb/video_sink.sv
// downstream video sink model, records every beat it takes
// assumes the bench drives mode at the falling edge
`timescale 1ns/10ps
module video_sink import video_rate_remapper_pkg::*; (
	input wire logic clk,
	input wire logic [MAX_PPB*PIXEL_BITS-1:0] tdata,
	input wire logic tvalid,
	input wire logic tuser,
	input wire logic tlast,
	input wire logic [1:0] mode, // 0 ready, 1 slow, 2 stalled
	output logic tready
);
	beat_t got[$]; // beats in arrival order
	logic [1:0] cnt = 2'h0; // slow mode takes one cycle in four
	initial tready = 1'b0;
	// ready changes only after falling edges
	always @(negedge clk) begin
		cnt <= cnt + 2'h1;
		tready <= mode == 2'h0 || (mode == 2'h1 && cnt == 2'h0);
	end
	// a beat counts only on valid and ready together
	always @(posedge clk) begin
		if (tvalid && tready) got.push_back({tuser, tlast, tdata});
	end
endmodule : video_sink

// file: tb/video_rate_remapper_tb.sv
// self-checking bench for the pixel rate remapper
// assumes the design, sink model and checker are compiled first
`timescale 1ns/10ps
module video_rate_remapper_tb;
	import video_rate_remapper_pkg::*;
	localparam int PB = PIXEL_BITS;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] s_axi_ctrl_awaddr = 8'h00, s_axi_ctrl_araddr = 8'h00;
	logic s_axi_ctrl_awvalid = 1'b0, s_axi_ctrl_wvalid = 1'b0, s_axi_ctrl_bready = 1'b0;
	logic s_axi_ctrl_arvalid = 1'b0, s_axi_ctrl_rready = 1'b0;
	logic [31:0] s_axi_ctrl_wdata = 32'h0, s_axi_ctrl_rdata, rd;
	logic [3:0] s_axi_ctrl_wstrb = 4'hF;
	logic s_axi_ctrl_awready, s_axi_ctrl_wready, s_axi_ctrl_bvalid;
	logic s_axi_ctrl_arready, s_axi_ctrl_rvalid;
	logic [1:0] s_axi_ctrl_bresp, s_axi_ctrl_rresp, resp;
	logic [MAX_PPB*PB-1:0] s_axis_video_tdata = '0, m_axis_video_tdata;
	logic s_axis_video_tvalid = 1'b0, s_axis_video_tuser = 1'b0, s_axis_video_tlast = 1'b0;
	logic s_axis_video_tready, m_axis_video_tvalid, m_axis_video_tready;
	logic m_axis_video_tuser, m_axis_video_tlast;
	logic [1:0] sink_mode = 2'h0;
	int num_errors = 0;
	int comparisons = 0;
	// register rows: address, reset value, value after writing ones, answer
	typedef struct {logic [7:0] a; logic [31:0] rst; logic [31:0] back; logic [1:0] r;} row_t;
	row_t regs[10] = '{'{OFS_FRAME_HEIGHT, 0, 32'hFFFF, RESP_OKAY},
		'{OFS_FRAME_WIDTH, 0, 32'hFFFF, RESP_OKAY}, '{OFS_COLOUR_FORMAT, 1, 32'hFF, RESP_OKAY},
		'{OFS_IN_PPB, 0, 32'hFF, RESP_OKAY}, '{OFS_OUT_PPB, 0, 32'hFF, RESP_OKAY},
		'{OFS_RSVD_A, 0, 0, RESP_OKAY}, '{OFS_RSVD_B, 0, 0, RESP_OKAY},
		'{OFS_DROP_EN, 0, 1, RESP_OKAY}, '{OFS_REPEAT_EN, 0, 1, RESP_OKAY},
		'{8'h60, 0, 0, RESP_SLVERR}};
	// stream rows: input code, output code, line width; other codes mean one
	int rates[11][3] = '{'{1, 1, 8}, '{1, 2, 8}, '{1, 4, 6}, '{2, 1, 8}, '{2, 2, 8}, '{2, 4, 6},
		'{4, 1, 8}, '{4, 2, 8}, '{4, 4, 8}, '{3, 4, 5}, '{0, 2, 3}};

	video_rate_remapper dut_u (.*);
	video_sink sink_u (.clk(clk), .tdata(m_axis_video_tdata), .tvalid(m_axis_video_tvalid),
		.tuser(m_axis_video_tuser), .tlast(m_axis_video_tlast), .mode(sink_mode),
		.tready(m_axis_video_tready));

	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task automatic limit(input int i);
		if (i >= 400) begin
			num_errors++;
			$display("[FAIL] %0t handshake timeout", $time);
			final_report();
		end
	endtask : limit
	task automatic check32(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask : check32
	task automatic check_beat(input beat_t g, input beat_t e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t beat %h expected %h", $time, g, e);
		end
	endtask : check_beat
	// distinct pattern in every component, so a swap shows
	function automatic logic [PB-1:0] pix(input int k);
		return {8'hA5, k[15:0], 8'h3C, ~k[15:0]};
	endfunction : pix
	function automatic int eff(input int n);
		return (n == 2 || n == 4) ? n : 1;
	endfunction : eff
	// ************************************************************
	// register bus, entered and left at a falling edge
	// ************************************************************
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		s_axi_ctrl_awaddr = a;
		s_axi_ctrl_wdata = d;
		s_axi_ctrl_awvalid = 1'b1;
		s_axi_ctrl_wvalid = 1'b1;
		for (i = 0; i < 400 && s_axi_ctrl_awready !== 1'b1; i++) @(posedge clk);
		limit(i);
		@(negedge clk);
		s_axi_ctrl_awvalid = 1'b0;
		s_axi_ctrl_wvalid = 1'b0;
		@(negedge clk);
		s_axi_ctrl_bready = 1'b1;
		resp = s_axi_ctrl_bresp;
		@(negedge clk);
		s_axi_ctrl_bready = 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		int i;
		s_axi_ctrl_araddr = a;
		s_axi_ctrl_arvalid = 1'b1;
		for (i = 0; i < 400 && s_axi_ctrl_arready !== 1'b1; i++) @(negedge clk);
		limit(i);
		@(negedge clk);
		s_axi_ctrl_arvalid = 1'b0;
		@(negedge clk);
		s_axi_ctrl_rready = 1'b1;
		rd = s_axi_ctrl_rdata;
		resp = s_axi_ctrl_rresp;
		@(negedge clk);
		s_axi_ctrl_rready = 1'b0;
	endtask : reg_read
	// ************************************************************
	// video stream
	// ************************************************************
	// valid stays high, so lines follow back to back
	task automatic send_line(input int ni, input int w, input int k0, input bit sof,
		input bit eol);
		int p, s, i;
		for (p = 0; p < w; p += ni) begin
			s_axis_video_tdata = '0;
			for (s = 0; s < ni && p + s < w; s++) s_axis_video_tdata[s*PB +: PB] = pix(k0 + p + s);
			s_axis_video_tuser = sof && p == 0;
			s_axis_video_tlast = eol && p + ni >= w;
			s_axis_video_tvalid = 1'b1;
			for (i = 0; i < 400 && s_axis_video_tready !== 1'b1; i++) @(negedge clk);
			limit(i);
			@(negedge clk);
		end
	endtask : send_line
	task automatic check_lines(input int no, input int w, input int lines, input int k0);
		int n, i, l, p, s;
		beat_t e;
		n = lines * ((w + no - 1) / no);
		for (i = 0; i < 400 && sink_u.got.size() < n; i++) @(negedge clk);
		limit(i);
		for (l = 0; l < lines; l++) begin
			for (p = 0; p < w; p += no) begin
				e = '0;
				for (s = 0; s < no && p + s < w; s++) e.pix[s] = pix(k0 + l*w + p + s);
				e.sof = l == 0 && p == 0;
				e.eol = p + no >= w;
				check_beat(sink_u.got.pop_front(), e);
			end
		end
		check32(32'(sink_u.got.size()), 32'h0);
	endtask : check_lines
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int k, n, w;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		foreach (regs[j]) begin
			reg_read(regs[j].a);
			check32(rd, regs[j].rst);
			reg_write(regs[j].a, 32'hFFFFFFFF);
			check32({30'h0, resp}, {30'h0, regs[j].r});
			reg_read(regs[j].a);
			check32(rd, regs[j].back);
		end
		k = 0;
		foreach (rates[j]) begin
			w = rates[j][2];
			reg_write(OFS_FRAME_WIDTH, 32'(w));
			reg_write(OFS_FRAME_HEIGHT, 32'h2);
			reg_write(OFS_IN_PPB, 32'(rates[j][0]));
			reg_write(OFS_OUT_PPB, 32'(rates[j][1]));
			sink_mode = 2'(j % 2);
			send_line(eff(rates[j][0]), w, k, 1'b1, 1'b1);
			send_line(eff(rates[j][0]), w, k + w, 1'b0, 1'b1);
			s_axis_video_tvalid = 1'b0;
			check_lines(eff(rates[j][1]), w, 2, k);
			k += 2 * w;
		end
		reg_read(OFS_STATUS);
		check32(rd, 32'h00020000);
		// stalled sink: the buffer must fill, refuse, then drain in order
		reg_write(OFS_IN_PPB, 32'h1);
		reg_write(OFS_OUT_PPB, 32'h1);
		sink_mode = 2'h2;
		for (n = 0; n < 60 && s_axis_video_tready === 1'b1; n++) send_line(1, 1, k + n, n == 0, 0);
		s_axis_video_tvalid = 1'b0;
		check32(32'(n >= FIFO_DEPTH && n < 60), 32'h1);
		sink_mode = 2'h0;
		@(negedge clk);
		send_line(1, 1, k + n, 1'b0, 1'b1);
		s_axis_video_tvalid = 1'b0;
		check_lines(1, n + 1, 1, k);
		// mid-run reset restores the format code
		reg_write(OFS_COLOUR_FORMAT, {24'h0, FMT_422_420});
		reg_read(OFS_COLOUR_FORMAT);
		check32(rd, {24'h0, FMT_422_420});
		nrst = 1'b0;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		reg_read(OFS_COLOUR_FORMAT);
		check32(rd, {24'h0, FMT_444});
		final_report();
	end
	// cuts a hang short
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		$display("[FAIL] %0t run limit reached", $time);
		final_report();
	end
endmodule : video_rate_remapper_tb
